//--- design/mtcs_pkg.sv
// constants for the transmit configuration and status block
// assumes a 32-bit classic Wishbone bus and a 20 MHz clock
package mtcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CMD    = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h04;
  localparam logic [5:0] IDX_NCOL   = 6'h05;
  localparam logic [5:0] IDX_CONFIG = 6'h0D;
  localparam logic [5:0] IDX_DCFG   = 6'h0E;
  // transmit_config fields
  localparam int CFG_CRC_INH = 0;
  localparam int CFG_LOOP_LO = 1;
  localparam int CFG_LOOP_HI = 2;
  localparam int CFG_RTD     = 3;
  localparam int CFG_BACKOFF_OFFSET_EN    = 4;
  // transmit_status fields
  localparam int ST_SENT = 0;
  localparam int ST_COL  = 2;
  localparam int ST_ABT  = 3;
  localparam int ST_CRS  = 4;
  localparam int ST_FU   = 5;
  localparam int ST_CDH  = 6;
  localparam int ST_OWC  = 7;
  // data_config_reg loop_select_bit, command and readback
  localparam int DCFG_LS   = 3;
  localparam int CMD_START = 0;
  // reset values
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] DCFG_RST   = 8'h04;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // loopback modes
  typedef enum logic [1:0] {
    LOOP_NONE = 2'b00,
    LOOP_MAC  = 2'b01,
    LOOP_CODEC = 2'b10,
    LOOP_EXT  = 2'b11
  } mtcs_loop_type;
  // retry, backoff and remote disable hash figures
  localparam logic [4:0] LAST_RETRY  = 5'd15;
  localparam logic [4:0] BACKOFF_OFFSET_EN_LIMIT  = 5'd3;
  localparam logic [4:0] BACKOFF_OFFSET_EN_ADD    = 5'd3;
  localparam logic [4:0] BACKOFF_CAP = 5'd10;
  localparam logic [5:0] HASH_OFF    = 6'd62;
  localparam logic [5:0] HASH_ON     = 6'd63;
  // times in ns and their cycle counts
  localparam int CLK_NS       = 50;
  localparam int SLOT_TIME_NS = 51200;
  localparam int HB_WINDOW_NS = 6400;
  localparam logic [10:0] SLOT_CYC = 11'(SLOT_TIME_NS / CLK_NS);
  localparam logic [10:0] HB_CYC   = 11'(HB_WINDOW_NS / CLK_NS);
endpackage

//--- design/mtcs_top.sv
// transmit configuration and transmit status logic of a 10 Mbit/s MAC
// assumes a classic Wishbone master and a media side synchronous to CLK_I
// What this block does
// - fcs appended unless crc inhibit bit set
// - crc inhibit still honoured in loopback
// - bits 2:1 select one of four loopbacks
// - only mode 2 drives loop_out high
// - loopback bits reset to zero
// - remote multicast 62 disables, 63 enables
// - clearing remote disable enable re-enables transmitter
// - offset backoff for first three collisions
// - status cleared when host starts transmission
// - status bits set only by events
// - sent_ok when no abort nor underrun
// - collision flag and collision count kept
// - abort after sixteen attempts collide
// - carrier loss flagged, transmission continues
// - underrun flagged and transmission aborted
// - heartbeat missing in gap window flagged
// - heartbeat flag may set after collisions
// - late collision flagged, retried as normal
// - status undefined before first transmission
// - loop_select_bit zero selects loopback; loop_out ignores it and stays high in mode 2
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mtcs_top
  import mtcs_pkg::*;
(
  input  wire logic        CLK_I,         // 20 MHz
  input  wire logic        RESET_I,       // async, high
  input  wire logic [7:0]  ADR_I,         // byte address
  input  wire logic [31:0] DAT_I,         // write data
  input  wire logic [3:0]  SEL_I,         // byte lanes
  input  wire logic        WE_I,          // write
  input  wire logic        CYC_I,         // cycle
  input  wire logic        STB_I,         // strobe
  output logic      [31:0] DAT_O,         // read data
  output logic             ACK_O,         // answer
  input  wire logic        COL_I,         // collision
  input  wire logic        CRS_I,         // carrier sense
  input  wire logic        UNDERRUN_I,    // fifo ran dry
  input  wire logic        FRAME_END_I,   // last bit sent
  input  wire logic        HASH_HIT_I,    // multicast received
  input  wire logic [5:0]  HASH_IDX_I,    // its hash index
  output logic             TX_EN_O,       // transmitting
  output logic             CRC_APPEND_O,  // append fcs
  output logic             LOOP_OUT_O,    // codec loopback
  output var mtcs_pkg::mtcs_loop_type LOOP_MODE_O, // loopback mode
  output logic             LOOP_EN_O,     // loopback active
  output logic             TX_DISABLED_O  // remote disabled
);
  import mtcs_pkg::*;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HOLD = 3'b001,
    S_SEND = 3'b010,
    S_BACK = 3'b011,
    S_GAP  = 3'b100
  } mtcs_state_type;

  mtcs_state_type state_q;     // sequencer state
  logic [7:0]  cfg_q;          // transmit_config
  logic [7:0]  dcfg_q;         // data_config_reg
  logic [7:0]  status_q;       // transmit_status
  logic [4:0]  ncol_q;         // collision_count_reg
  logic        tx_off_q;       // remote disable held
  logic        ack_q;          // bus answer
  logic [31:0] rdat_q;         // read data
  logic [31:0] rdat_d;         // read mux
  logic [10:0] tmr_q;          // cycle timer
  logic [9:0]  slots_q;        // backoff slots left
  logic [15:0] lfsr_q;         // random source
  logic        hb_seen_q;      // heartbeat seen in gap
  logic        req;            // new bus request
  logic        wr;             // accepted write
  logic        start;          // host starts a frame
  logic        col_ev;         // collision while sending
  logic        last_try;       // this collision aborts
  logic        late;           // past one slot time
  logic        gap_end;        // heartbeat window over
  logic [9:0]  draw;           // backoff slot count

  // mask of the random draw for collision number n
  function automatic logic [9:0] bo_mask(
    input logic [4:0] n,
    input logic       backoff_offset_en
  );
    logic [4:0] r;
    r = n;
    // low priority mode widens the first three draws
    if (backoff_offset_en && (n <= BACKOFF_OFFSET_EN_LIMIT)) begin
      r = 5'(n + BACKOFF_OFFSET_EN_ADD);
    end
    if (r > BACKOFF_CAP) begin
      r = BACKOFF_CAP;
    end
    bo_mask = 10'((11'h001 << r) - 11'h001);
  endfunction

  // bus decode; one request answered once
  assign req = CYC_I & STB_I & ~ack_q;
  // a write lands at the edge where the master samples ack high
  assign wr  = CYC_I & STB_I & WE_I & SEL_I[0] & ack_q;

  // host start only taken when idle
  assign start = wr & (ADR_I[7:2] == IDX_CMD)
               & DAT_I[CMD_START]
               & (state_q == S_IDLE);

  // media events in the sending state and the gap window
  assign col_ev   = (state_q == S_SEND) & COL_I;
  assign last_try = (ncol_q == LAST_RETRY);
  assign late     = (tmr_q == SLOT_CYC);
  assign gap_end  = (state_q == S_GAP)
                  & (tmr_q == HB_CYC - 11'h001);

  // backoff draw from the low lfsr bits
  assign draw = lfsr_q[9:0]
              & bo_mask(5'(ncol_q + 5'h01), cfg_q[CFG_BACKOFF_OFFSET_EN]);

  // classic wishbone answer one cycle after request
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (ADR_I[7:2])
      IDX_CMD: begin
        rdat_d[0] = (state_q != S_IDLE);
        rdat_d[1] = tx_off_q;
      end
      IDX_STATUS: rdat_d[7:0] = status_q;
      IDX_NCOL:   rdat_d[4:0] = ncol_q;
      IDX_CONFIG: rdat_d[7:0] = cfg_q;
      IDX_DCFG:   rdat_d[7:0] = dcfg_q;
      default:    rdat_d = 32'h0000_0000;
    endcase
  end

  // read data captured with the answer
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rdat_q <= 32'h0000_0000;
    end else if (req & ~WE_I) begin
      rdat_q <= rdat_d;
    end
  end

  // transmit_config; loopback bits come up clear
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_q <= CFG_RST;
    end else if (wr & (ADR_I[7:2] == IDX_CONFIG)) begin
      // reserved bits 7:5 stay zero
      cfg_q <= {3'b000, DAT_I[4:0]};
    end
  end

  // data_config_reg; only loop_select_bit is used here
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      dcfg_q <= DCFG_RST;
    end else if (wr & (ADR_I[7:2] == IDX_DCFG)) begin
      dcfg_q <= {1'b0, DAT_I[6:0]};
    end
  end

  // remote transmitter disable
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_off_q <= 1'b0;
    end else if (!cfg_q[CFG_RTD]) begin
      // feature off releases the transmitter
      tx_off_q <= 1'b0;
    end else if (HASH_HIT_I && (HASH_IDX_I == HASH_OFF)) begin
      tx_off_q <= 1'b1;
    end else if (HASH_HIT_I && (HASH_IDX_I == HASH_ON)) begin
      tx_off_q <= 1'b0;
    end
  end

  // free running lfsr; reseeds never, so draws are repeatable
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // transmit sequencer
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q <= S_IDLE;
      tmr_q   <= 11'h000;
      slots_q <= 10'h000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_HOLD;
          end
        end
        // wait here while a remote station holds us off
        S_HOLD: begin
          if (!tx_off_q) begin
            state_q <= S_SEND;
            tmr_q   <= 11'h000;
          end
        end
        S_SEND: begin
          // timer stops at one slot; only late matters
          if (tmr_q != SLOT_CYC) begin
            tmr_q <= tmr_q + 11'h001;
          end
          if (UNDERRUN_I) begin
            state_q <= S_IDLE;
          end else if (COL_I) begin
            if (last_try) begin
              state_q <= S_IDLE;
            end else begin
              // late or not, the retry is the same
              state_q <= S_BACK;
              slots_q <= draw;
              tmr_q   <= 11'h000;
            end
          end else if (FRAME_END_I) begin
            state_q <= S_GAP;
            tmr_q   <= 11'h000;
          end
        end
        // wait the drawn number of slot times
        S_BACK: begin
          if (slots_q == 10'h000) begin
            state_q <= S_SEND;
            tmr_q   <= 11'h000;
          end else if (tmr_q == SLOT_CYC - 11'h001) begin
            tmr_q   <= 11'h000;
            slots_q <= slots_q - 10'h001;
          end else begin
            tmr_q <= tmr_q + 11'h001;
          end
        end
        // heartbeat window of the interframe gap
        S_GAP: begin
          if (gap_end) begin
            state_q <= S_IDLE;
          end else begin
            tmr_q <= tmr_q + 11'h001;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // heartbeat seen during the gap window
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      hb_seen_q <= 1'b0;
    end else if (state_q == S_SEND) begin
      hb_seen_q <= 1'b0;
    end else if ((state_q == S_GAP) && COL_I) begin
      hb_seen_q <= 1'b1;
    end
  end

  // collision count for the current frame
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ncol_q <= 5'h00;
    end else if (start) begin
      ncol_q <= 5'h00;
    end else if (col_ev & ~UNDERRUN_I) begin
      ncol_q <= ncol_q + 5'h01;
    end
  end

  // transmit_status: cleared at start, then sticky per frame
  // events cannot coincide with start, which only fires when idle
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      // value before first frame carries no meaning
      status_q <= STATUS_RST;
    end else if (start) begin
      status_q <= 8'h00;
    end else if (state_q == S_SEND) begin
      // bits only rise on their own events
      if (!CRS_I) begin
        status_q[ST_CRS] <= 1'b1;
      end
      if (UNDERRUN_I) begin
        status_q[ST_FU] <= 1'b1;
      end else if (COL_I) begin
        status_q[ST_COL] <= 1'b1;
        if (late) begin
          status_q[ST_OWC] <= 1'b1;
        end
        if (last_try) begin
          status_q[ST_ABT] <= 1'b1;
        end
      end else if (FRAME_END_I) begin
        // reached only without abort or underrun
        status_q[ST_SENT] <= 1'b1;
      end
    end else if (gap_end && !hb_seen_q && !COL_I) begin
      // a collision burst can mask the test too
      status_q[ST_CDH] <= 1'b1;
    end
  end

  // loopback decode; the codec pin ignores loop_select_bit
  assign LOOP_MODE_O = mtcs_loop_type'(
                       {cfg_q[CFG_LOOP_HI], cfg_q[CFG_LOOP_LO]});
  assign LOOP_OUT_O  = (LOOP_MODE_O == LOOP_CODEC);
  assign LOOP_EN_O   = ~dcfg_q[DCFG_LS]
                     & (LOOP_MODE_O != LOOP_NONE);

  // fcs control holds in every mode
  assign CRC_APPEND_O = ~cfg_q[CFG_CRC_INH];

  // remaining outputs
  assign TX_EN_O       = (state_q == S_SEND) & ~tx_off_q;
  assign TX_DISABLED_O = tx_off_q;
  assign ACK_O         = ack_q;
  assign DAT_O         = rdat_q;
endmodule
`default_nettype wire

//--- sim/mtcs_assertions.sv
// checker for the transmit config and status block ports
// assumes a bind onto mtcs_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module mtcs_assertions
  import mtcs_pkg::*;
(
  input wire logic                   CLK_I,
  input wire logic                   RESET_I,
  input wire logic [7:0]             ADR_I,
  input wire logic [31:0]            DAT_I,
  input wire logic [3:0]             SEL_I,
  input wire logic                   WE_I,
  input wire logic                   CYC_I,
  input wire logic                   STB_I,
  input wire logic                   ACK_O,
  input wire logic                   HASH_HIT_I,
  input wire logic [5:0]             HASH_IDX_I,
  input wire logic                   TX_EN_O,
  input wire logic                   CRC_APPEND_O,
  input wire logic                   LOOP_OUT_O,
  input wire mtcs_pkg::mtcs_loop_type LOOP_MODE_O,
  input wire logic                   LOOP_EN_O,
  input wire logic                   TX_DISABLED_O
);
  import mtcs_pkg::*;
  logic wr_cfg;  // config write taken this edge
  logic wr_dcfg; // data config write taken
  logic rtd_q;   // mirror of remote disable enable
  logic ls_q;    // mirror of loop select bit
  assign wr_cfg = CYC_I && STB_I && WE_I && SEL_I[0] && ACK_O && ADR_I[7:2] == IDX_CONFIG;
  assign wr_dcfg = CYC_I && STB_I && WE_I && SEL_I[0] && ACK_O && ADR_I[7:2] == IDX_DCFG;
  // mirrors kept here since those bits never reach a port
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rtd_q <= 1'b0;
      ls_q  <= DCFG_RST[DCFG_LS];
    end else begin
      if (wr_cfg) rtd_q <= DAT_I[CFG_RTD];
      if (wr_dcfg) ls_q <= DAT_I[DCFG_LS];
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  crc_follows_a: assert property (wr_cfg |=> CRC_APPEND_O == !$past(DAT_I[0]))
    else $error("crc append does not follow inhibit bit");
  mode_follows_a: assert property (wr_cfg |=> LOOP_MODE_O == $past(DAT_I[2:1]))
    else $error("loop mode does not follow field");
  codec_loop_a: assert property (LOOP_OUT_O == (LOOP_MODE_O == LOOP_CODEC))
    else $error("loop output wrong for mode");
  reset_mode_a: assert property ($fell(RESET_I) |-> LOOP_MODE_O == LOOP_NONE)
    else $error("loop mode not cleared by reset");
  loop_enable_a: assert property (LOOP_EN_O == (LOOP_MODE_O != LOOP_NONE && !ls_q))
    else $error("loop enable wrong");
  disabled_quiet_a: assert property (TX_DISABLED_O |-> !TX_EN_O)
    else $error("sending while remote disabled");
  remote_off_a: assert property (HASH_HIT_I && rtd_q && HASH_IDX_I == HASH_OFF
    |=> TX_DISABLED_O)
    else $error("hash 62 did not disable");
  remote_on_a: assert property (HASH_HIT_I && rtd_q && HASH_IDX_I == HASH_ON
    |=> !TX_DISABLED_O)
    else $error("hash 63 did not enable");
  // the cleared enable reaches the disable flag one edge after the write lands
  rtd_clear_a: assert property (wr_cfg && !DAT_I[CFG_RTD] |=> ##1 !TX_DISABLED_O)
    else $error("clearing enable kept disable");
  cover property ($rose(TX_EN_O));
  cover property ($rose(TX_DISABLED_O));
  cover property (wr_cfg && DAT_I[2:1] == 2'b10);
endmodule
bind mtcs_top mtcs_assertions u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
  .HASH_HIT_I(HASH_HIT_I), .HASH_IDX_I(HASH_IDX_I), .TX_EN_O(TX_EN_O),
  .CRC_APPEND_O(CRC_APPEND_O), .LOOP_OUT_O(LOOP_OUT_O), .LOOP_MODE_O(LOOP_MODE_O),
  .LOOP_EN_O(LOOP_EN_O), .TX_DISABLED_O(TX_DISABLED_O));
`default_nettype wire

//--- sim/mtcs_medium.sv
// far-side medium model: collision, carrier, underrun, frame end
// assumes the block's transmit enable and one shared clock
`timescale 1ns/1ps
`default_nettype none
module mtcs_medium (
  input  wire logic       clk_i,   // block clock
  input  wire logic       rst_i,   // async reset
  input  wire logic       tx_en_i, // block sending
  input  wire logic       hb_i,    // heartbeat test on
  input  wire logic [1:0] mode_i,  // 0 clean 1 collide 2 carrier 3 underrun
  output logic            col_o,   // collision level
  output logic            crs_o,   // carrier sense
  output logic            und_o,   // fifo underrun
  output logic            end_o    // last bit pulse
);
  logic [7:0] cnt_q; // cycles into this attempt
  logic [7:0] gap_q; // cycles into the gap, 0 idle
  logic       hit_q; // one collision per frame only
  // counters follow the block's sending state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      gap_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= tx_en_i ? cnt_q + 8'h01 : 8'h00;
      gap_q <= end_o ? 8'h01 : (gap_q != 8'h00 ? gap_q + 8'h01 : 8'h00);
      hit_q <= end_o ? 1'b0 : (hit_q | (col_o & tx_en_i));
    end
  end
  // idle line shows no carrier, so a stale level never leaks
  assign crs_o = tx_en_i && !(mode_i == 2'd2 && cnt_q > 8'd10);
  assign col_o = (tx_en_i && mode_i == 2'd1 && cnt_q == 8'd5 && !hit_q) || (hb_i && gap_q == 8'd20);
  assign und_o = tx_en_i && mode_i == 2'd3 && cnt_q == 8'd8;
  assign end_o = tx_en_i && cnt_q == 8'd40;
endmodule
`default_nettype wire

//--- sim/mtcs_top_test.sv
// self-checking bench for the transmit config and status block
// assumes mtcs_medium as far side; reads checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
module mtcs_top_test;
  import mtcs_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          we = 1'b0, cyc = 1'b0, stb = 1'b0, hit = 1'b0, hb = 1'b1;
  logic [7:0]    adr = 8'h00;
  logic [31:0]   dat = 32'h0000_0000;
  logic [3:0]    sel = 4'h1;
  logic [5:0]    idx = 6'h00;
  logic [1:0]    mode = 2'b00;
  logic [31:0]   dat_o, r;
  logic          ack, col, carrier_lost_flag, und, fend, tx_en;
  mtcs_loop_type lmode;
  logic [63:0]   q[$];  // expected {mask, value} per read
  logic [63:0]   note;  // oldest expectation taken by the monitor
  logic [7:0]    tbl[5] = '{8'h01, 8'h05, 8'h11, 8'h20, 8'h41};
  int            n_errors = 0;
  int            checks = 0;
  int            seed = 46246;
  always #25 clk = ~clk;
  mtcs_top DUT (.CLK_I(clk), .RESET_I(rst), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel),
    .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack), .COL_I(col),
    .CRS_I(carrier_lost_flag), .UNDERRUN_I(und), .FRAME_END_I(fend), .HASH_HIT_I(hit),
    .HASH_IDX_I(idx), .TX_EN_O(tx_en), .CRC_APPEND_O(), .LOOP_OUT_O(),
    .LOOP_MODE_O(lmode), .LOOP_EN_O(), .TX_DISABLED_O());
  mtcs_medium u_med (.clk_i(clk), .rst_i(rst), .tx_en_i(tx_en), .hb_i(hb),
    .mode_i(mode), .col_o(col), .crs_o(carrier_lost_flag), .und_o(und), .end_o(fend));
  // one classic cycle; held until ack is sampled high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({m, e});
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  // one receive hash pulse from the address filter
  task automatic hash(input logic [5:0] v);
    hit <= 1'b1;
    idx <= v;
    @(posedge clk);
    hit <= 1'b0;
    @(posedge clk);
  endtask
  // monitor: read data is taken at the ack edge only
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = q.pop_front();
      checks++;
      if ((dat_o & note[63:32]) !== note[31:0]) begin
        n_errors++;
        $display("CHECK FAILED read %h expected %h seen %h", adr, note[31:0], dat_o);
      end
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well past the roughly 12700 cycles needed
  initial begin
    #(40000 * 50);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF); // unmapped reads zero
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      bus(8'h38, 1'b1, {28'h0, i[2], 3'b100});
      bus(8'h34, 1'b1, {27'h0, r[4], 1'b0, i[1:0], r[0]});
      rd(8'h34, {27'h0, r[4], 1'b0, i[1:0], r[0]}, 32'hFF);
      checks++;
      if (lmode !== mtcs_loop_type'(i[1:0])) begin
        n_errors++;
        $display("CHECK FAILED loop mode expected %0d seen %0d", i[1:0], lmode);
      end
    end
    bus(8'h34, 1'b1, 32'h0000_0000);
    // status not read before the first start has cleared it
    for (int i = 0; i < 5; i++) begin
      mode <= i[1:0];
      hb <= (i != 4);
      bus(8'h00, 1'b1, 32'h0000_0001);
      rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
      repeat (2500) @(posedge clk);
      rd(8'h10, {24'h0, tbl[i]}, 32'hFF ^ {25'h0, i[0], 6'h0});
      rd(8'h14, (i == 1) ? 32'h1 : 32'h0, 32'hFFFF_FFFF);
    end
    hash(6'd62);
    rd(8'h00, 32'h0000_0000, 32'h0000_0002);
    bus(8'h34, 1'b1, 32'h0000_0008);
    hash(6'd62);
    rd(8'h00, 32'h0000_0002, 32'h0000_0002);
    hash(6'd63);
    rd(8'h00, 32'h0000_0000, 32'h0000_0002);
    hash(6'd62);
    bus(8'h34, 1'b1, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000, 32'h0000_0002);
    end_of_test();
  end
endmodule
`default_nettype wire
